// ---- spc_ctrl.sv ----
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
module spc_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_instr,
  input wire logic crystal_selected,
  input wire logic converter_enabled,
  input wire spc_pkg::spc_wake_t wake_req,
  input wire logic reset_wake,
  input wire logic [3:0] module_access,
  output spc_pkg::spc_gate_t gates,
  output logic [3:0] module_access_ok,
  output logic core_halted,
  output logic irq_resume,
  output logic conv_start,
  output logic conv_extended,
  output logic detector_on
);
  import spc_pkg::*;

  // Everything that remembers anything lives in this one record, so reset and state
  // inspection have a single place to look. The bus slave keeps only the low byte of
  // write data, because every register here is eight bits or narrower.
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [3:0] aw_addr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic [3:0] shutdown;
    logic [2:0] unlock_tmr;
    logic [2:0] arm_tmr;
    logic [2:0] hold_tmr;
    logic sleep_off_active;
    spc_state_t state;
    spc_kind_t kind;
    logic detector_off;
    logic [11:0] wake_cnt;
    logic conv_start;
    logic conv_was_on;
    logic conv_extended;
  } spc_state_all_t;

  spc_state_all_t cur_ff;
  spc_state_all_t nxt_cur;
  spc_kind_t sel_kind;
  logic wake_ok;
  logic sleeping;

  assign sel_kind = spc_kind_t'(cur_ff.ctrl[POS_KIND_HI:POS_KIND_LO]);
  assign sleeping = (cur_ff.state == ST_SLEEP);

  // Watchdog interrupts count in every kind, because the watchdog runs from its own
  // oscillator and keeps going whatever the main clocks do.
  // Wake qualification per kind; edge form of interrupt zero never counts in deep modes.
  always_comb begin
    unique case (cur_ff.kind)
      KIND_IDLE: wake_ok = |wake_req;
      KIND_NOISE: wake_ok = wake_req.conv_done | wake_req.store_ready | wake_req.ext_level_zero |
        wake_req.pin_change | wake_req.watchdog_irq;
      KIND_DOWN, KIND_STANDBY: wake_ok = wake_req.ext_level_zero | wake_req.pin_change |
        wake_req.watchdog_irq;
    endcase
  end

  // Clock gating follows the chosen kind while asleep.
  always_comb begin
    gates.core_clock = !sleeping;
    gates.program_memory_clock = !sleeping;
    gates.peripheral_io_clock = !sleeping || cur_ff.kind == KIND_IDLE;
    gates.converter_clock = !sleeping || cur_ff.kind == KIND_IDLE || cur_ff.kind == KIND_NOISE;
    gates.oscillator = !sleeping || cur_ff.kind != KIND_DOWN;
    // Module clocks gate from the shutdown bits and the io clock, so deeper modes already stop them.
    gates.module_clock = ~cur_ff.shutdown & {4{gates.peripheral_io_clock}};
  end

  assign module_access_ok = module_access & ~cur_ff.shutdown;
  assign core_halted = cur_ff.state != ST_RUN;
  // Core returns to the next instruction only for an interrupt wake, reset takes the vector path.
  assign irq_resume = cur_ff.state == ST_WAKE && cur_ff.wake_cnt == CNT_ONE;
  assign conv_start = cur_ff.conv_start;
  assign conv_extended = cur_ff.conv_extended;
  assign detector_on = !cur_ff.detector_off;
  // The slave answers every access with OKAY; unmapped reads return zero and unmapped
  // writes vanish. Ready drops while a response is pending, which keeps at most one
  // write and one read in flight without any queue.
  assign s_axi_awready = !cur_ff.aw_got && !cur_ff.bvalid;
  assign s_axi_wready = !cur_ff.w_got && !cur_ff.bvalid;
  assign s_axi_bvalid = cur_ff.bvalid;
  assign s_axi_bresp = 2'h0;
  assign s_axi_arready = !cur_ff.rvalid;
  assign s_axi_rvalid = cur_ff.rvalid;
  assign s_axi_rdata = cur_ff.rdata;
  assign s_axi_rresp = 2'h0;

  // Next-state logic for the bus slave, timed unlock and sleep sequencer.
  always_comb begin
    logic wr_go;
    logic [7:0] wv;
    nxt_cur = cur_ff;
    wr_go = 1'b0;
    wv = cur_ff.wdata;
    nxt_cur.conv_start = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_cur.aw_got = 1'b1;
      nxt_cur.aw_addr = s_axi_awaddr[3:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_cur.w_got = 1'b1;
      nxt_cur.wdata = s_axi_wdata[7:0];
      nxt_cur.wstrb0 = s_axi_wstrb[0];
    end
    if (cur_ff.aw_got && cur_ff.w_got) begin
      wr_go = cur_ff.wstrb0;
      nxt_cur.aw_got = 1'b0;
      nxt_cur.w_got = 1'b0;
      nxt_cur.bvalid = 1'b1;
    end
    if (cur_ff.bvalid && s_axi_bready) nxt_cur.bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_cur.rvalid = 1'b1;
      unique case (s_axi_araddr[3:0])
        // The sleep-off bit is stored as zero, so a read shows whether the timed window is live.
        ADDR_POWER_CONTROL: nxt_cur.rdata = {24'h0, cur_ff.sleep_off_active, cur_ff.ctrl[POS_SLEEP_OFF-1:0]};
        ADDR_MODULE_SHUTDOWN: nxt_cur.rdata = {28'h0, cur_ff.shutdown};
        ADDR_STATUS: nxt_cur.rdata = {27'h0, cur_ff.conv_extended, cur_ff.detector_off, cur_ff.kind, sleeping};
        default: nxt_cur.rdata = 32'h0;
      endcase
    end
    if (cur_ff.rvalid && s_axi_rready) nxt_cur.rvalid = 1'b0;
    // Unlock window and sleep-off arming counters.
    if (cur_ff.unlock_tmr != 3'h0) nxt_cur.unlock_tmr = cur_ff.unlock_tmr - TMR_ONE;
    // The hold countdown runs first so that a fresh arm landing in the same cycle wins over the clear.
    if (cur_ff.hold_tmr != 3'h0) begin
      nxt_cur.hold_tmr = cur_ff.hold_tmr - TMR_ONE;
      if (cur_ff.hold_tmr == TMR_ONE) nxt_cur.sleep_off_active = 1'b0;
    end
    if (cur_ff.arm_tmr != 3'h0) begin
      nxt_cur.arm_tmr = cur_ff.arm_tmr - TMR_ONE;
      if (cur_ff.arm_tmr == TMR_ONE) begin
        nxt_cur.sleep_off_active = 1'b1;
        nxt_cur.hold_tmr = 3'(SLEEP_OFF_HOLD);
      end
    end
    if (wr_go && cur_ff.aw_addr == ADDR_POWER_CONTROL) begin
      nxt_cur.ctrl = wv & ~(8'h1 << POS_SLEEP_OFF);
      if (wv[POS_SLEEP_OFF] && wv[POS_UNLOCK]) begin
        nxt_cur.unlock_tmr = 3'(UNLOCK_WINDOW);
      end else if (wv[POS_SLEEP_OFF] && cur_ff.unlock_tmr != 3'h0) begin
        nxt_cur.arm_tmr = 3'(SLEEP_OFF_DELAY);
        nxt_cur.unlock_tmr = 3'h0;
      end
    end
    if (wr_go && cur_ff.aw_addr == ADDR_MODULE_SHUTDOWN) nxt_cur.shutdown = wv[3:0] & SHUTDOWN_MASK;
    // Converter off then on forces the next conversion to be extended.
    nxt_cur.conv_was_on = converter_enabled;
    if (converter_enabled && !cur_ff.conv_was_on) nxt_cur.conv_extended = 1'b1;
    else if (cur_ff.conv_start) nxt_cur.conv_extended = 1'b0;
    // Sleep sequencer; storage is never touched, so register file and SRAM persist.
    unique case (cur_ff.state)
      ST_RUN: begin
        if (sleep_instr && cur_ff.ctrl[POS_SLEEP_ENABLE] &&
            (sel_kind != KIND_STANDBY || crystal_selected)) begin
          nxt_cur.state = ST_SLEEP;
          nxt_cur.kind = sel_kind;
          nxt_cur.detector_off = cur_ff.sleep_off_active && sel_kind[1];
          nxt_cur.conv_start = converter_enabled && !sel_kind[1];
        end
      end
      ST_SLEEP: begin
        if (reset_wake) begin
          nxt_cur.state = ST_RUN;
          nxt_cur.detector_off = 1'b0;
        end else if (wake_ok) begin
          nxt_cur.state = ST_WAKE;
          nxt_cur.detector_off = 1'b0;
          if (cur_ff.detector_off) nxt_cur.wake_cnt = 12'(DETECTOR_WAKE_CYC);
          else if (cur_ff.kind == KIND_STANDBY) nxt_cur.wake_cnt = 12'(STANDBY_WAKE);
          else if (cur_ff.kind == KIND_DOWN) nxt_cur.wake_cnt = 12'(OSC_START_CYC + WAKE_HALT);
          else nxt_cur.wake_cnt = 12'(WAKE_HALT);
        end
      end
      ST_WAKE: begin
        if (reset_wake) nxt_cur.state = ST_RUN;
        else if (cur_ff.wake_cnt == CNT_ONE) nxt_cur.state = ST_RUN;
        else nxt_cur.wake_cnt = cur_ff.wake_cnt - CNT_ONE;
      end
      default: nxt_cur.state = ST_RUN;
    endcase
  end

  // Single state register; synchronous reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_ff <= '0;
      cur_ff.ctrl <= CTRL_RESET;
      cur_ff.shutdown <= SHUTDOWN_RESET;
      cur_ff.state <= ST_RUN;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  sequence unlock_write_s;
    cur_ff.unlock_tmr != 3'h0 && nxt_cur.arm_tmr == 3'(SLEEP_OFF_DELAY) && cur_ff.arm_tmr != nxt_cur.arm_tmr;
  endsequence

  sleep_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(sleeping) |-> $past(cur_ff.ctrl[POS_SLEEP_ENABLE])) else $error("sleep without enable");
  idle_clocks_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sleeping && cur_ff.kind == KIND_IDLE |-> !gates.core_clock && gates.peripheral_io_clock)
    else $error("idle clocks wrong");
  noise_clocks_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sleeping && cur_ff.kind == KIND_NOISE |-> !gates.peripheral_io_clock && gates.converter_clock)
    else $error("noise clocks wrong");
  down_osc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sleeping && cur_ff.kind == KIND_DOWN |-> !gates.oscillator && !gates.converter_clock)
    else $error("power-down oscillator running");
  edge_nowake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sleeping && cur_ff.kind[1] && !reset_wake && wake_req.ext_edge_zero && !wake_req.ext_level_zero &&
    !wake_req.pin_change && !wake_req.watchdog_irq |=> sleeping)
    else $error("edge interrupt woke deep sleep");
  idle_halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sleeping && cur_ff.kind == KIND_IDLE && !cur_ff.detector_off && wake_ok && !reset_wake
    |=> core_halted [*4] ##1 !core_halted) else $error("halt length wrong");
  reset_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    core_halted && reset_wake |=> !core_halted && !irq_resume) else $error("reset did not wake");
  conv_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(sleeping) && !cur_ff.kind[1] && $past(converter_enabled) |-> conv_start)
    else $error("no conversion at entry");
  detector_back_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cur_ff.state == ST_WAKE |-> detector_on) else $error("detector not restored");
  unlock_arm_a: assert property (@(posedge aclk) disable iff (!aresetn)
    unlock_write_s |-> ##4 cur_ff.sleep_off_active ##3 !cur_ff.sleep_off_active)
    else $error("sleep-off timing wrong");
  shutdown_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    |cur_ff.shutdown |-> (module_access_ok & cur_ff.shutdown) == 4'h0) else $error("access to shut module");

  // Wake-up budget per kind, counted in halted cycles after the wake is seen.
  // Idle and noise halt for the interrupt entry only; power-down adds the oscillator
  // start-up; standby keeps the oscillator and so finishes in its own short count.
  // A sleep with the detector off waits long enough for the detector to settle.
  // That long wait is checked at its load point rather than by a long delay, which
  // keeps the property cheap; the counter itself is the same one the short waits use.
  sequence deep_wake_s;
    sleeping && cur_ff.kind == KIND_DOWN && !cur_ff.detector_off && wake_ok && !reset_wake;
  endsequence

  sequence standby_wake_s;
    sleeping && cur_ff.kind == KIND_STANDBY && !cur_ff.detector_off && wake_ok && !reset_wake;
  endsequence

  sequence detector_wake_s;
    sleeping && cur_ff.detector_off && wake_ok && !reset_wake;
  endsequence

  // Halt lengths and the long detector wait.
  down_halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    deep_wake_s
    |=> ##19 core_halted ##1 !core_halted)
    else $error("power-down wake length wrong");
  standby_halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    standby_wake_s
    |=> core_halted [*6] ##1 !core_halted)
    else $error("standby wake length wrong");
  detector_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
    detector_wake_s
    |=> core_halted && cur_ff.wake_cnt == 12'(DETECTOR_WAKE_CYC))
    else $error("detector wake too short");

  // Clock domains and wake sources per kind.
  standby_osc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sleeping && cur_ff.kind == KIND_STANDBY
    |-> gates.oscillator && !gates.converter_clock && !gates.peripheral_io_clock)
    else $error("standby clocks wrong");
  noise_nowake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sleeping && cur_ff.kind == KIND_NOISE && !reset_wake && !wake_req.conv_done && !wake_req.store_ready &&
    !wake_req.ext_level_zero && !wake_req.pin_change && !wake_req.watchdog_irq |=> sleeping)
    else $error("noise mode woke on other source");
  idle_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sleeping && cur_ff.kind == KIND_IDLE && !reset_wake && wake_req.other_io
    |=> cur_ff.state == ST_WAKE)
    else $error("idle did not wake");
  module_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sleeping && cur_ff.kind != KIND_IDLE
    |-> gates.module_clock == 4'h0)
    else $error("module clock running in deep sleep");

  // Detector sleep-off and converter bookkeeping.
  sleep_off_kind_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sleeping && !cur_ff.kind[1]
    |-> detector_on)
    else $error("detector off in shallow sleep");
  unlock_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cur_ff.arm_tmr == 3'(SLEEP_OFF_DELAY)
    |-> $past(cur_ff.unlock_tmr) != 3'h0)
    else $error("sleep-off armed without unlock");
  conv_ext_a: assert property (@(posedge aclk) disable iff (!aresetn)
    converter_enabled && !cur_ff.conv_was_on
    |=> conv_extended)
    else $error("re-enable not extended");
endmodule : spc_ctrl

// ---- spc_pkg.sv ----
package spc_pkg;
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [3:0] ADDR_POWER_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_MODULE_SHUTDOWN = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  // Field positions in the power control register.
  localparam int POS_SLEEP_OFF = 7;
  localparam int POS_SLEEP_ENABLE = 5;
  localparam int POS_KIND_HI = 4;
  localparam int POS_KIND_LO = 3;
  localparam int POS_UNLOCK = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] SHUTDOWN_MASK = 4'hf;
  localparam logic [3:0] SHUTDOWN_RESET = 4'h0;
  // Timing figures.
  localparam int CLK_MHZ = 50;
  localparam int UNLOCK_WINDOW = 4;
  localparam int SLEEP_OFF_DELAY = 3;
  localparam int SLEEP_OFF_HOLD = 3;
  localparam int WAKE_HALT = 4;
  localparam int STANDBY_WAKE = 6;
  localparam int DETECTOR_WAKE_US = 60;
  localparam int DETECTOR_WAKE_CYC = DETECTOR_WAKE_US * CLK_MHZ;
  localparam int OSC_START_CYC = 16;
  localparam logic [11:0] CNT_ONE = 12'h001;
  localparam logic [2:0] TMR_ONE = 3'h1;

  typedef enum logic [1:0] {
    KIND_IDLE = 2'b00,
    KIND_NOISE = 2'b01,
    KIND_DOWN = 2'b10,
    KIND_STANDBY = 2'b11
  } spc_kind_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE = 2'b10
  } spc_state_t;

  // Wake sources presented by the surrounding core.
  typedef struct packed {
    logic ext_level_zero;
    logic ext_edge_zero;
    logic pin_change;
    logic store_ready;
    logic conv_done;
    logic watchdog_irq;
    logic other_io;
  } spc_wake_t;

  // Clock gates toward the core.
  typedef struct packed {
    logic core_clock;
    logic program_memory_clock;
    logic peripheral_io_clock;
    logic converter_clock;
    logic oscillator;
    logic [3:0] module_clock;
  } spc_gate_t;
endpackage : spc_pkg

// ---- spc_core_model.sv ----
`timescale 1ns/100ps
module spc_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic issue,
  input wire logic core_halted,
  output logic sleep_instr
);
  // A halted core fetches nothing, so a sleep instruction can only issue while running.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_instr <= 1'b0;
    end else begin
      sleep_instr <= issue & ~core_halted;
    end
  end
endmodule : spc_core_model

// ---- spc_ctrl_tb_top.sv ----
`timescale 1ns/100ps
module spc_ctrl_tb_top;
  import spc_pkg::*;
  typedef struct packed {
    logic [1:0] kind;
    logic [6:0] bad;
    logic [6:0] good;
    logic [8:0] gate;
    logic conv;
    logic [11:0] min_wait;
  } spc_row_t;
  logic aclk = 1'b0, aresetn = 1'b0, issue = 1'b0, sleep_instr;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bvalid, bready = 1'b0, arvalid = 1'b0, rvalid, rready = 1'b0;
  logic awready, wready, arready, core_halted, irq_resume, conv_start, conv_extended, detector_on;
  logic [1:0] bresp, rresp;
  logic crystal_selected = 1'b1, converter_enabled = 1'b1, reset_wake = 1'b0;
  logic [3:0] module_access = 4'h0, module_access_ok;
  spc_wake_t wake_req = '0;
  spc_gate_t gates;
  logic seen_resume = 1'b0, seen_conv = 1'b0;
  logic [31:0] rd;
  int failures = 0, n_compared = 0, n;
  spc_row_t rows [4] = '{
    '{2'b00, 7'h00, 7'h01, 9'h07f, 1'b1, WAKE_HALT},
    '{2'b01, 7'h01, 7'h04, 9'h030, 1'b1, WAKE_HALT},
    '{2'b10, 7'h21, 7'h10, 9'h000, 1'b0, OSC_START_CYC + WAKE_HALT},
    '{2'b11, 7'h21, 7'h10, 9'h010, 1'b0, STANDBY_WAKE}};
  // The clock toggles every half period of 10 ns.
  always #10 aclk = ~aclk;
  spc_core_model core (.aclk(aclk), .aresetn(aresetn), .issue(issue), .core_halted(core_halted),
    .sleep_instr(sleep_instr));
  spc_ctrl uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sleep_instr(sleep_instr),
    .crystal_selected(crystal_selected), .converter_enabled(converter_enabled), .wake_req(wake_req),
    .reset_wake(reset_wake), .module_access(module_access), .gates(gates),
    .module_access_ok(module_access_ok), .core_halted(core_halted), .irq_resume(irq_resume),
    .conv_start(conv_start), .conv_extended(conv_extended), .detector_on(detector_on));
  // One-cycle pulses are caught here so a test can ask afterwards whether they occurred.
  always @(negedge aclk) begin
    if (irq_resume === 1'b1) seen_resume <= 1'b1;
    if (conv_start === 1'b1) seen_conv <= 1'b1;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task test_done;
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  // Handshakes are sampled at the falling edge, where they equal what the next rising edge sees.
  task axi_write(input logic [31:0] a, input logic [31:0] d);
    logic aw, w, ra, rw, rb;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    aw = 1'b1; w = 1'b1; rb = 1'b0;
    while (!rb) begin
      @(negedge aclk);
      ra = awready; rw = wready; rb = bvalid;
      @(posedge aclk);
      if (aw && ra === 1'b1) begin awvalid <= 1'b0; aw = 1'b0; end
      if (w && rw === 1'b1) begin wvalid <= 1'b0; w = 1'b0; end
    end
    bready <= 1'b0;
  endtask : axi_write
  task axi_read(input logic [31:0] a, output logic [31:0] d);
    logic ar, rv;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    ar = 1'b1; rv = 1'b0;
    while (!rv) begin
      @(negedge aclk);
      rv = rvalid; d = rdata;
      if (ar && arready === 1'b1) begin @(posedge aclk); arvalid <= 1'b0; ar = 1'b0; end
      else @(posedge aclk);
    end
    rready <= 1'b0;
  endtask : axi_read
  task sleep_now;
    seen_resume <= 1'b0; seen_conv <= 1'b0;
    @(posedge aclk) issue <= 1'b1;
    @(posedge aclk) issue <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : sleep_now
  // The wake level stays up until the core leaves the halted state.
  task wake_up(input logic [6:0] src);
    @(posedge aclk) wake_req <= src;
    n = 0;
    @(negedge aclk);
    while (core_halted === 1'b1 && n < 4000) begin @(negedge aclk); n++; end
    @(posedge aclk) wake_req <= '0;
    repeat (2) @(posedge aclk);
  endtask : wake_up
  // A hang is cut short well after the slowest wake-up sequence.
  initial begin
    #400000;
    failures++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check(gates, 9'h1ff);
    check(detector_on, 1'b1);
    axi_read(32'h0, rd);
    check(rd, {24'h0, CTRL_RESET});
    check(conv_extended, 1'b1);
    $display("test reset done");
    axi_write(32'h0, 32'h10);
    sleep_now();
    check(core_halted, 1'b0);
    $display("test no_enable done");
    foreach (rows[i]) begin
      axi_write(32'h0, 32'h20 | (rows[i].kind << 3));
      sleep_now();
      check(core_halted, 1'b1);
      check(gates, rows[i].gate);
      check(seen_conv, rows[i].conv);
      @(posedge aclk) wake_req <= rows[i].bad;
      repeat (30) @(posedge aclk);
      check(core_halted, 1'b1);
      wake_up(rows[i].good);
      check(core_halted, 1'b0);
      check(seen_resume, 1'b1);
      check(n, rows[i].min_wait + 1);
      check(gates, 9'h1ff);
      $display("test sleep kind %0d done", i);
    end
    axi_write(32'h0, 32'h20);
    sleep_now();
    @(posedge aclk) reset_wake <= 1'b1;
    while (core_halted === 1'b1) @(posedge aclk);
    reset_wake <= 1'b0;
    @(posedge aclk);
    check(seen_resume, 1'b0);
    $display("test reset_wake done");
    axi_write(32'h0, 32'h80);
    axi_read(32'h0, rd);
    check(rd[POS_SLEEP_OFF], 1'b0);
    // Unlock, then arm inside the window, then sleep in power-down while the bit is live.
    axi_write(32'h0, 32'h84);
    axi_write(32'h0, 32'hb0);
    sleep_now();
    check(core_halted, 1'b1);
    check(detector_on, 1'b0);
    wake_up(7'h10);
    check(n, DETECTOR_WAKE_CYC + 1);
    check(detector_on, 1'b1);
    @(posedge aclk) converter_enabled <= 1'b0;
    @(posedge aclk) converter_enabled <= 1'b1;
    repeat (2) @(negedge aclk);
    check(conv_extended, 1'b1);
    $display("test sleep_off done");
    axi_write(32'h4, 32'hff);
    axi_read(32'h4, rd);
    check(rd, 32'h0f);
    @(posedge aclk) module_access <= 4'hf;
    @(negedge aclk);
    check(module_access_ok, 4'h0);
    check(gates.module_clock, 4'h0);
    axi_write(32'h4, 32'h00);
    @(negedge aclk);
    check(module_access_ok, 4'hf);
    axi_read(32'hc, rd);
    check(rd, 32'h0);
    $display("test shutdown done");
    test_done();
  end
endmodule : spc_ctrl_tb_top
